/* File: rtl/ctrl_pkg.sv */
// Constants for the control-port and power-mode block of the audio converter.
// Assumes a single 25 MHz system clock; the design's addresses, pages, timing and field positions live here.
package ctrl_pkg;
  // Clock and timing
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int WAKE_TIME_US = 1000;
  localparam int WAKE_CYCLES = WAKE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int RAMP_TIME_US = 1000;
  localparam int RAMP_CYCLES = RAMP_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int CNT_W = 17;

  // Target address
  localparam logic [4:0] ADDR_FIXED_HI = 5'h13;
  localparam logic [6:0] ADDR_BROADCAST = 7'h4c;

  // Register map, page scheme
  localparam logic [6:0] REG_PAGE = 7'h00;
  localparam logic [6:0] REG_SOFT_RESET = 7'h01;
  localparam logic [6:0] REG_SLEEP = 7'h02;
  localparam logic [6:0] REG_INPUT_CHANNEL_ENABLES = 7'h73;
  localparam logic [6:0] REG_OUT_CH_EN = 7'h74;
  localparam logic [6:0] REG_PWR_UP = 7'h75;
  localparam logic [6:0] REG_STATUS_A = 7'h76;
  localparam logic [6:0] REG_STATUS_B = 7'h77;
  localparam logic [7:0] PAGE_CFG = 8'h00;
  localparam logic [7:0] PAGE_COEF_FIRST = 8'h02;
  localparam logic [7:0] PAGE_COEF_LAST = 8'h04;
  localparam int MEM_BANKS = 4;
  localparam int MEM_DEPTH = MEM_BANKS * 128;
  localparam int MEM_AW = 9;

  // Field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int SLEEP_DISABLE_N_BIT = 0;
  localparam int BROADCAST_BIT = 2;
  localparam int REG_SELECT_BIT = 7;
  localparam int PWR_ADC_BIT = 6;
  localparam int STS_SLEEP_BIT = 7;
  localparam int STS_ACTIVE_BIT = 6;

  // Reset values
  localparam logic [7:0] SLEEP_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_ADDR, I_REG, I_ACK_REG, I_WR, I_ACK_WR, I_RD, I_ACK_RD
  } i2c_state_t;

  typedef enum logic [2:0] {P_SLEEP, P_WAKE, P_ACTIVE, P_RAMP, P_DOWN} pwr_state_t;
endpackage

/* File: rtl/ctrl_port.sv */
// Control port and power-mode sequencer: I2C target with paged 8-bit registers,
// protocol detection, sleep / active / soft-reset handling.
// Assumes bus pins and straps arrive asynchronously; the bench resolves the
// open-drain data wire from data_or_select_pin_oe.
`timescale 1ns/1ps
`default_nettype none
module ctrl_port
  import ctrl_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES,
  parameter int RAMP_COUNT = RAMP_CYCLES
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus pins
  input wire logic scl_pin,
  input wire logic data_or_select_pin_in,
  output logic data_or_select_pin_out,
  output logic data_or_select_pin_oe,
  input wire logic addr_strap_low_pin,
  input wire logic addr_strap_high_pin,
  // Detected protocol
  output logic interface_is_i2c,
  output logic interface_is_spi,
  // Power control
  output logic analog_power_en,
  output logic digital_power_en,
  output logic volume_ramp_active,
  output logic device_in_sleep,
  output logic regulator_source_select,
  output logic [7:0] channel_power
);

  // Two-stage synchronisers, third stage only for edge finding
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic stl_s1, stl_s2, stl_s3, sth_s1, sth_s2;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else if (ce)
    begin
      {scl_s1, scl_s2, scl_s3} <= {scl_pin, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {data_or_select_pin_in, sda_s1, sda_s2};
    end
  end

  // Strap synchronisers run through reset: settled when caught, no false toggle
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      {stl_s1, stl_s2, stl_s3} <= {addr_strap_low_pin, stl_s1, stl_s2};
      {sth_s1, sth_s2} <= {addr_strap_high_pin, sth_s1};
    end
  end

  // Four clocks per bus clock phase cover the fastest bus rate
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_cond = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
  wire stop_cond = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

  // Shared state declarations
  i2c_state_t i_state_reg;
  pwr_state_t p_state_reg;
  logic [7:0] page_reg, sleep_reg, in_ch_reg, pwr_up_reg, status_a_reg, status_b_reg;
  logic [7:0] shift_reg, tx_reg, rd_byte;
  logic [6:0] ptr_reg, wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [3:0] bit_cnt_reg;
  logic rw_reg, wr_pulse_reg, armed_reg;
  logic [1:0] strap_reg;
  logic [MEM_AW-1:0] clr_cnt_reg;
  logic clr_busy_reg;
  logic [CNT_W-1:0] p_cnt_reg;
  logic [7:0] mem [MEM_DEPTH];

  // Straps caught once after reset release, then held
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_reg <= 2'h0;
      armed_reg <= 1'b1;
    end
    else if (ce && armed_reg)
    begin
      strap_reg <= {sth_s2, stl_s2};
      armed_reg <= 1'b0;
    end
  end

  // Protocol detection locks on first evidence; straps never move under I2C
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      interface_is_i2c <= 1'b0;
      interface_is_spi <= 1'b0;
    end
    else if (ce && !interface_is_i2c && !interface_is_spi)
    begin
      if (start_cond)
        interface_is_i2c <= 1'b1;
      else if (!armed_reg && (stl_s2 != stl_s3))
        interface_is_spi <= 1'b1;
    end
  end

  // Address match, broadcast overrides the straps
  wire [6:0] own_addr = sleep_reg[BROADCAST_BIT] ? ADDR_BROADCAST :
                        {ADDR_FIXED_HI, strap_reg};
  wire soft_req = wr_pulse_reg && (wr_addr_reg == REG_SOFT_RESET) &&
                  (page_reg == PAGE_CFG) && wr_data_reg[SOFT_RESET_BIT];
  wire init = rst || soft_req;

  // Page to storage bank; unlisted pages have no storage
  function automatic logic page_ok(input logic [7:0] pg);
    page_ok = (pg == PAGE_CFG) || ((pg >= PAGE_COEF_FIRST) && (pg <= PAGE_COEF_LAST));
  endfunction
  function automatic logic [1:0] bank_of(input logic [7:0] pg);
    bank_of = (pg == PAGE_CFG) ? 2'h0 : 2'(pg - 8'h01);
  endfunction

  // Read mux over the paged map
  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_reg == REG_PAGE)
      rd_byte = page_reg;
    else if (page_reg == PAGE_CFG && ptr_reg == REG_SOFT_RESET)
      rd_byte = 8'h00;
    else if (page_reg == PAGE_CFG && ptr_reg == REG_SLEEP)
      rd_byte = sleep_reg;
    else if (page_reg == PAGE_CFG && ptr_reg == REG_STATUS_A)
      rd_byte = status_a_reg;
    else if (page_reg == PAGE_CFG && ptr_reg == REG_STATUS_B)
      rd_byte = status_b_reg;
    else if (page_ok(page_reg))
      rd_byte = mem[{bank_of(page_reg), ptr_reg}];
  end

  // I2C target engine; held idle while storage is being cleared
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      i_state_reg <= I_IDLE;
      data_or_select_pin_oe <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 7'h00;
      rw_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
    end
    else if (ce)
    begin
      wr_pulse_reg <= 1'b0;
      // The very first start both selects I2C and opens a transfer
      if (interface_is_spi || clr_busy_reg || (!interface_is_i2c && !start_cond))
      begin
        i_state_reg <= I_IDLE;
        data_or_select_pin_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        // Repeated start also ends a write burst
        i_state_reg <= I_ADDR;
        bit_cnt_reg <= 4'h0;
        data_or_select_pin_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        i_state_reg <= I_IDLE;
        data_or_select_pin_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        // Bits sampled on the rising clock, MSB first
        case (i_state_reg)
          I_ADDR, I_REG, I_WR:
          begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          I_RD:
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          I_ACK_RD:
            if (sda_s2)
              i_state_reg <= I_IDLE;
          default:
            bit_cnt_reg <= bit_cnt_reg;
        endcase
      end
      else if (scl_fall)
      begin
        // Drive changes only just after the falling clock
        case (i_state_reg)
          I_ADDR:
            if (bit_cnt_reg == 4'h8)
            begin
              if (shift_reg[7:1] == own_addr)
              begin
                rw_reg <= shift_reg[0];
                data_or_select_pin_oe <= 1'b1;
                i_state_reg <= I_ACK_ADDR;
              end
              else
                i_state_reg <= I_IDLE;
            end
          I_ACK_ADDR:
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg <= rd_byte;
              data_or_select_pin_oe <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 7'h01;
              i_state_reg <= I_RD;
            end
            else
            begin
              data_or_select_pin_oe <= 1'b0;
              i_state_reg <= I_REG;
            end
          end
          I_REG:
            if (bit_cnt_reg == 4'h8)
            begin
              ptr_reg <= shift_reg[6:0];
              data_or_select_pin_oe <= 1'b1;
              i_state_reg <= I_ACK_REG;
            end
          I_WR:
            if (bit_cnt_reg == 4'h8)
            begin
              wr_pulse_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 7'h01;
              data_or_select_pin_oe <= 1'b1;
              i_state_reg <= I_ACK_WR;
            end
          I_ACK_REG, I_ACK_WR:
          begin
            // No byte limit: keep taking data until stop or start
            bit_cnt_reg <= 4'h0;
            data_or_select_pin_oe <= 1'b0;
            i_state_reg <= I_WR;
          end
          I_RD:
            if (bit_cnt_reg == 4'h8)
            begin
              data_or_select_pin_oe <= 1'b0;
              i_state_reg <= I_ACK_RD;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              data_or_select_pin_oe <= ~tx_reg[6];
            end
          I_ACK_RD:
          begin
            // Controller acked: next byte from the advanced pointer
            bit_cnt_reg <= 4'h0;
            tx_reg <= rd_byte;
            data_or_select_pin_oe <= ~rd_byte[7];
            ptr_reg <= ptr_reg + 7'h01;
            i_state_reg <= I_RD;
          end
          default:
            i_state_reg <= I_IDLE;
        endcase
      end
    end
  end

  // Open-drain: the pin is only ever pulled low
  always_ff @(posedge clk)
  begin
    if (rst)
      data_or_select_pin_out <= 1'b0;
    else if (ce)
      data_or_select_pin_out <= 1'b0;
  end

  // Page and sleep registers; page write works from any page
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      page_reg <= PAGE_RESET;
      sleep_reg <= SLEEP_RESET;
    end
    else if (ce && wr_pulse_reg)
    begin
      if (wr_addr_reg == REG_PAGE)
        page_reg <= wr_data_reg;
      else if (page_reg == PAGE_CFG && wr_addr_reg == REG_SLEEP)
        sleep_reg <= wr_data_reg;
    end
  end

  // Shadow copies of the enable register for channel gating and of the power-up register for the sequencer
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      in_ch_reg <= 8'h00;
      pwr_up_reg <= 8'h00;
    end
    else if (ce && wr_pulse_reg && page_reg == PAGE_CFG)
    begin
      if (wr_addr_reg == REG_INPUT_CHANNEL_ENABLES)
        in_ch_reg <= wr_data_reg;
      else if (wr_addr_reg == REG_PWR_UP)
        pwr_up_reg <= wr_data_reg;
    end
  end

  // Register storage; a sweep clears it after reset, costing 512 cycles of NACK
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      clr_busy_reg <= 1'b1;
      clr_cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (clr_busy_reg)
      begin
        mem[clr_cnt_reg] <= 8'h00;
        clr_cnt_reg <= clr_cnt_reg + 1'b1;
        if (clr_cnt_reg == MEM_AW'(MEM_DEPTH - 1))
          clr_busy_reg <= 1'b0;
      end
      else if (wr_pulse_reg && page_ok(page_reg) && wr_addr_reg != REG_PAGE &&
               !(page_reg == PAGE_CFG && (wr_addr_reg == REG_STATUS_A ||
                 wr_addr_reg == REG_STATUS_B)))
        mem[{bank_of(page_reg), wr_addr_reg}] <= wr_data_reg;
    end
  end

  // Power sequencer: sleep, wake wait, active, ramp-down, power-down
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      p_state_reg <= P_SLEEP;
      p_cnt_reg <= '0;
      analog_power_en <= 1'b0;
      digital_power_en <= 1'b0;
      volume_ramp_active <= 1'b0;
      device_in_sleep <= 1'b1;
    end
    else if (ce)
    begin
      case (p_state_reg)
        P_SLEEP:
          if (sleep_reg[SLEEP_DISABLE_N_BIT])
          begin
            p_state_reg <= P_WAKE;
            p_cnt_reg <= '0;
            device_in_sleep <= 1'b0;
          end
        P_WAKE:
          if (p_cnt_reg == CNT_W'(WAKE_COUNT - 1))
          begin
            p_state_reg <= P_ACTIVE;
            digital_power_en <= 1'b1;
          end
          else
            p_cnt_reg <= p_cnt_reg + 1'b1;
        P_ACTIVE:
          if (!sleep_reg[SLEEP_DISABLE_N_BIT])
          begin
            p_state_reg <= P_RAMP;
            p_cnt_reg <= '0;
            volume_ramp_active <= 1'b1;
          end
          else
            analog_power_en <= pwr_up_reg[PWR_ADC_BIT];
        P_RAMP:
          if (p_cnt_reg == CNT_W'(RAMP_COUNT - 1))
          begin
            p_state_reg <= P_DOWN;
            volume_ramp_active <= 1'b0;
            analog_power_en <= 1'b0;
          end
          else
            p_cnt_reg <= p_cnt_reg + 1'b1;
        P_DOWN:
        begin
          digital_power_en <= 1'b0;
          device_in_sleep <= 1'b1;
          p_state_reg <= P_SLEEP;
        end
        default:
          p_state_reg <= P_SLEEP;
      endcase
    end
  end

  // Live status registers and pins
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      status_a_reg <= 8'h00;
      status_b_reg <= 8'h80;
      channel_power <= 8'h00;
      regulator_source_select <= 1'b0;
    end
    else if (ce)
    begin
      status_a_reg <= in_ch_reg & {8{analog_power_en}};
      channel_power <= in_ch_reg & {8{analog_power_en}};
      status_b_reg <= 8'h00;
      status_b_reg[STS_SLEEP_BIT] <= device_in_sleep;
      status_b_reg[STS_ACTIVE_BIT] <= (p_state_reg == P_ACTIVE);
      regulator_source_select <= sleep_reg[REG_SELECT_BIT];
    end
  end

endmodule // ctrl_port
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// Bus controller model for the control port: drives clock, pulls data low.
// Assumes the bench resolves the wired-AND data level and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
(
  // Bus wires
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam time Q = 80;
  // Idle bus at start; the model drives the clock high, the pull-up holds data high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask
  // Eight bits MSB first, then the acknowledge slot; data moves only with clock low
  task automatic tx(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
    output logic ack_seen);
    logic [8:0] s;
    s = {d, ack_in};
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = ~s[i];
      #Q scl = 1'b1;
      #(2*Q) s[i] = sda; // Late in the high phase, after the device has settled
      scl = 1'b0;
      #Q;
    end
    q = s[8:1];
    ack_seen = ~s[0];
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: tb/ctrl_port_checker.sv */
// Checker for the control port, watching only its top-level pins.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_checker
#(
  parameter int WAKE_COUNT = 20,
  parameter int RAMP_COUNT = 40
)
(
  // System and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic data_or_select_pin_out,
  input wire logic data_or_select_pin_oe,
  // Status
  input wire logic interface_is_i2c,
  input wire logic interface_is_spi,
  input wire logic analog_power_en,
  input wire logic digital_power_en,
  input wire logic volume_ramp_active,
  input wire logic device_in_sleep,
  input wire logic [7:0] channel_power
);
  localparam int RAMP_MAX = RAMP_COUNT + 4;
  localparam int WAKE_MAX = WAKE_COUNT + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Steps of the ramp-down into sleep
  sequence ramp_end_s;
    volume_ramp_active ##1 !volume_ramp_active;
  endsequence
  sequence asleep_s;
    device_in_sleep && !digital_power_en && !analog_power_en;
  endsequence
  open_drain_a:
    assert property (data_or_select_pin_out == 1'b0) else $error("data pin driven high");
  oe_clock_low_a:
    assert property ($changed(data_or_select_pin_oe) |-> !$past(scl_pin) && !$past(scl_pin, 2))
    else $error("data drive moved with clock high");
  proto_one_a:
    assert property (!(interface_is_i2c && interface_is_spi)) else $error("both protocols");
  proto_sticky_a:
    assert property (interface_is_i2c |=> interface_is_i2c) else $error("protocol flag lost");
  sleep_off_a:
    assert property (device_in_sleep |-> !analog_power_en && !digital_power_en)
    else $error("power on in sleep");
  analog_dig_a:
    assert property (analog_power_en |-> digital_power_en) else $error("analog without digital");
  ramp_len_a:
    assert property ($rose(volume_ramp_active) |-> ##[1:RAMP_MAX] !volume_ramp_active)
    else $error("ramp too long");
  ramp_sleep_a:
    assert property (ramp_end_s |-> ##[0:2] asleep_s) else $error("no sleep after ramp");
  chan_gate_a:
    assert property (!analog_power_en |=> channel_power == 8'h00) else $error("channels on");
  wake_len_a:
    assert property (!device_in_sleep && !digital_power_en |-> ##[1:WAKE_MAX] digital_power_en)
    else $error("wake too long");
endmodule // ctrl_port_checker
bind ctrl_port ctrl_port_checker #(.WAKE_COUNT(WAKE_COUNT), .RAMP_COUNT(RAMP_COUNT)) chk
(
  .clk(clk), .rst(rst), .scl_pin(scl_pin), .data_or_select_pin_out(data_or_select_pin_out),
  .data_or_select_pin_oe(data_or_select_pin_oe), .interface_is_i2c(interface_is_i2c),
  .interface_is_spi(interface_is_spi), .analog_power_en(analog_power_en),
  .digital_power_en(digital_power_en), .volume_ramp_active(volume_ramp_active),
  .device_in_sleep(device_in_sleep), .channel_power(channel_power)
);
`default_nettype wire

/* File: tb/i2c_control_and_power_modes_tb.sv */
// Self-checking bench for the control port: bus access, paging, power modes.
// Assumes the host model in i2c_host_model.sv and the checker bound to ctrl_port.
`timescale 1ns/1ps
`default_nettype none
module i2c_control_and_power_modes_tb;
  localparam int WC = 20;
  localparam int RC = 40;
  localparam int LIMIT = 20000;
  localparam logic [6:0] DEV = 7'h4e; // High strap 1, low strap 0
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic strap_lo = 1'b0;
  logic strap_hi = 1'b1;
  logic scl, sda_low, sda, oe, out, is_i2c, is_spi, ana, dig, ramp, slp, regsel;
  logic [7:0] chan;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  assign sda = ~(sda_low | (oe & ~out)); // Wired-AND with pull-up
  i2c_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
  ctrl_port #(.WAKE_COUNT(WC), .RAMP_COUNT(RC)) uut
  (
    .clk(clk), .rst(rst), .ce(ce), .scl_pin(scl), .data_or_select_pin_in(sda),
    .data_or_select_pin_out(out), .data_or_select_pin_oe(oe),
    .addr_strap_low_pin(strap_lo), .addr_strap_high_pin(strap_hi),
    .interface_is_i2c(is_i2c), .interface_is_spi(is_spi), .analog_power_en(ana),
    .digital_power_en(dig), .volume_ramp_active(ramp), .device_in_sleep(slp),
    .regulator_source_select(regsel), .channel_power(chan)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One byte from the host with the acknowledge compared
  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic [7:0] q;
    logic ak;
    host.tx(b, 1'b1, q, ak);
    check({7'h00, ak}, {7'h00, exp_ack});
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d[$]);
    host.start();
    put({dev, 1'b0}, 1'b1);
    put(r, 1'b1);
    foreach (d[i])
      put(d[i], 1'b1);
    host.stop();
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] e[$]);
    logic [7:0] q;
    logic ak;
    host.start();
    put({dev, 1'b0}, 1'b1);
    put(r, 1'b1);
    host.start();
    put({dev, 1'b1}, 1'b1);
    foreach (e[i])
    begin
      host.tx(8'hff, i == e.size() - 1, q, ak); // Last byte refused by the host
      check(q, e[i]);
    end
    host.stop();
    cyc(1);
  endtask
  task automatic nack(input logic [6:0] dev);
    host.start();
    put({dev, 1'b0}, 1'b0);
    host.stop();
    cyc(1);
  endtask
  // Hang guard: far above the few thousand cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    cyc(20);
    rst = 1'b0;
    cyc(530); // Storage clear sweep ignores the bus
    nack(7'h4c);
    check({7'h00, is_i2c}, 8'h01);
    check({7'h00, is_spi}, 8'h00);
    wr(DEV, 8'h02, '{8'h81});
    cyc(WC + 10);
    check({5'h00, dig, slp, regsel}, 8'h05);
    wr(DEV, 8'h00, '{8'h02});
    wr(DEV, 8'h7f, '{8'h11});
    rd(DEV, 8'h7f, '{8'h11, 8'h02});
    wr(DEV, 8'h00, '{8'h00});
    wr(DEV, 8'h73, '{8'ha5, 8'h0f, 8'h40});
    cyc(4);
    check({7'h00, ana}, 8'h01);
    check(chan, 8'ha5);
    wr(DEV, 8'h76, '{8'h00});
    rd(DEV, 8'h73, '{8'ha5, 8'h0f, 8'h40, 8'ha5});
    wr(DEV, 8'h02, '{8'h85});
    nack(DEV);
    wr(7'h4c, 8'h02, '{8'h80});
    check({7'h00, ramp}, 8'h01);
    cyc(RC + 10);
    check({5'h00, ana, dig, slp}, 8'h01);
    cyc(10 * RC);
    wr(DEV, 8'h02, '{8'h81});
    cyc(WC + 10);
    rd(DEV, 8'h73, '{8'ha5, 8'h0f});
    // Soft reset drops the engine right after its data byte, so no acknowledge
    host.start();
    put({DEV, 1'b0}, 1'b1);
    put(8'h01, 1'b1);
    put(8'h01, 1'b0);
    host.stop();
    cyc(1);
    check({5'h00, dig, slp, regsel}, 8'h02);
    cyc(530);
    wr(DEV, 8'h02, '{8'h01});
    cyc(WC + 10);
    rd(DEV, 8'h00, '{8'h00, 8'h00, 8'h01});
    rd(DEV, 8'h73, '{8'h00});
    // Second reset in mid-run: a strap toggle before any start means SPI
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(4);
    strap_lo = 1'b1;
    cyc(4);
    check({7'h00, is_spi}, 8'h01);
    nack(7'h4c);
    check({7'h00, is_i2c}, 8'h00);
    give_verdict();
  end
endmodule // i2c_control_and_power_modes_tb
`default_nettype wire
